//--- src/addr_table_mem.sv
`timescale 1ns/1ns
`default_nettype none
module addr_table_mem #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 16
) (
  input  wire logic clk_sys,  // System clock
  input  wire logic rst_n,    // Async reset, active low
  cam_port_if.mem   port      // Write and read port
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  // Table contents are not touched by reset
  always_ff @(posedge clk_sys) begin
    if (port.wr_en) begin
      mem_q[port.wr_idx] <= port.wr_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      port.rd_data <= '0;
    end else begin
      port.rd_data <= mem_q[port.rd_idx];
    end
  end
endmodule
`default_nettype wire

//--- src/cam_port_if.sv
`timescale 1ns/1ns
`default_nettype none
interface cam_port_if #(
  parameter int WIDTH = 48,
  parameter int IDX_W = 4
);
  logic             wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [WIDTH-1:0] wr_data;
  logic [IDX_W-1:0] rd_idx;
  logic [WIDTH-1:0] rd_data;

  modport ctrl (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport mem  (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface
`default_nettype wire

//--- src/rx_cam_compress_reject_filter.sv
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "rx_filter_params.svh"
module rx_cam_compress_reject_filter #(
  parameter int ADDR_W  = 8,
  parameter int ENTRIES = 16,
  parameter int IDX_W   = 4
) (
  input  wire logic              clk_sys,              // 10 MHz system clock
  input  wire logic              rst_n,                // Async reset, active low
  input  wire logic              psel,                 // APB select
  input  wire logic              penable,              // APB enable
  input  wire logic              pwrite,               // APB write
  input  wire logic [ADDR_W-1:0] paddr,                // APB byte address
  input  wire logic [31:0]       pwdata,               // APB write data
  output logic      [31:0]       prdata,               // APB read data
  output logic                   pready,               // APB ready
  output logic                   pslverr,              // APB error
  input  wire logic              frame_da_valid,       // Destination address complete
  input  wire logic [47:0]       frame_da,             // Destination address
  output logic                   compress_request_out, // Compress request level
  output logic                   compress_request_oe,  // Compress pin driven
  output logic                   decision_valid,       // Decision pulse
  output logic                   frame_accept,         // Accept pulse
  output logic                   frame_reject          // Reject pulse
);

  ////////////////////////////////////////////////////////////////////////////
  cam_port_if #(.WIDTH(48), .IDX_W(IDX_W)) cam ();

  addr_table_mem #(.WIDTH(48), .DEPTH(ENTRIES)) u_mem (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .port    (cam)
  );

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    case (a)
      `CTRL_OFS, `CAM_EN_OFS, `CAM_IDX_OFS, `CAM_LO_OFS, `CAM_MID_OFS,
      `CAM_HI_OFS, `CAM_CMD_OFS, `STATUS_OFS, `COUNT_OFS: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [`CTRL_W-1:0]  ctrl_ff;
  logic [ENTRIES-1:0]  cam_en_ff;
  logic [IDX_W-1:0]    cam_idx_ff;
  logic [15:0]         stage_lo_ff;
  logic [15:0]         stage_mid_ff;
  logic [15:0]         stage_hi_ff;
  logic [15:0]         acc_cnt_ff;
  logic [15:0]         rej_cnt_ff;
  logic                overrun_ff;
  logic                last_hit_ff;
  logic                last_bcast_ff;
  logic                busy;
  logic                access;
  logic                wr_fire;
  logic [31:0]         nxt_rdata;

  rx_filter_pkg::scan_state_e state_ff;
  rx_filter_pkg::mac_addr_t   da_ff;
  logic [IDX_W-1:0]           scan_idx_ff;
  logic [IDX_W-1:0]           cmp_idx_ff;
  logic                       cmp_vld_ff;
  logic                       hit_ff;
  logic                       cmp_hit;
  logic                       final_hit;
  logic                       is_bcast;
  logic                       is_mcast;
  logic                       decide;
  logic                       nxt_accept;
  logic                       nxt_compress;

  wire logic cfg_cmatch = ctrl_ff[`CTRL_CMATCH_BIT];
  wire logic cfg_cmiss  = ctrl_ff[`CTRL_CMISS_BIT];
  wire logic cfg_reject = ctrl_ff[`CTRL_REJECT_BIT];
  wire logic cfg_bcast  = ctrl_ff[`CTRL_BCAST_BIT];
  wire logic cfg_phys   = ctrl_ff[`CTRL_PHYS_BIT];
  wire logic cfg_mcast  = ctrl_ff[`CTRL_MCAST_BIT];

  // One wait state: ready rises in the second access cycle
  assign access  = psel && penable;
  assign wr_fire = access && pready && pwrite;
  assign busy    = (state_ff != rx_filter_pkg::ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (paddr)
      `CTRL_OFS:    nxt_rdata[`CTRL_W-1:0] = ctrl_ff;
      `CAM_EN_OFS:  nxt_rdata[ENTRIES-1:0] = cam_en_ff;
      `CAM_IDX_OFS: nxt_rdata[IDX_W-1:0] = cam_idx_ff;
      `CAM_LO_OFS:  nxt_rdata[15:0] = stage_lo_ff;
      `CAM_MID_OFS: nxt_rdata[15:0] = stage_mid_ff;
      `CAM_HI_OFS:  nxt_rdata[15:0] = stage_hi_ff;
      `STATUS_OFS:  nxt_rdata[5:0] = {overrun_ff, compress_request_out, compress_request_oe,
                                      last_bcast_ff, last_hit_ff, busy};
      `COUNT_OFS:   nxt_rdata = {rej_cnt_ff, acc_cnt_ff};
      default:      nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= access && !pready;
      prdata  <= (access && !pready && !pwrite) ? nxt_rdata : 32'h0000_0000;
      pslverr <= access && !pready && !is_mapped(paddr);
    end
  end

  // Configuration and table staging registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff      <= `CTRL_RST;
      cam_en_ff    <= `CAM_EN_RST;
      cam_idx_ff   <= `CAM_IDX_RST;
      stage_lo_ff  <= 16'h0000;
      stage_mid_ff <= 16'h0000;
      stage_hi_ff  <= 16'h0000;
    end else if (wr_fire) begin
      case (paddr)
        `CTRL_OFS:    ctrl_ff <= pwdata[`CTRL_W-1:0];
        `CAM_EN_OFS:  cam_en_ff <= pwdata[ENTRIES-1:0];
        `CAM_IDX_OFS: cam_idx_ff <= pwdata[IDX_W-1:0];
        `CAM_LO_OFS:  stage_lo_ff <= pwdata[15:0];
        `CAM_MID_OFS: stage_mid_ff <= pwdata[15:0];
        `CAM_HI_OFS:  stage_hi_ff <= pwdata[15:0];
        default: begin
        end
      endcase
    end
  end

  assign cam.wr_en   = wr_fire && (paddr == `CAM_CMD_OFS) && pwdata[`CAM_CMD_LOAD_BIT];
  assign cam.wr_idx  = cam_idx_ff;
  assign cam.wr_data = {stage_hi_ff, stage_mid_ff, stage_lo_ff};
  assign cam.rd_idx  = scan_idx_ff;

  // Overrun: a frame arriving mid-scan is dropped; set wins over clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      overrun_ff <= 1'b0;
    end else if (frame_da_valid && busy) begin
      overrun_ff <= 1'b1;
    end else if (wr_fire && (paddr == `STATUS_OFS) && pwdata[`STAT_OVERRUN_BIT]) begin
      overrun_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Table scan, one entry per cycle, read data one cycle behind the index
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff    <= rx_filter_pkg::ST_IDLE;
      da_ff       <= '0;
      scan_idx_ff <= '0;
    end else begin
      case (state_ff)
        rx_filter_pkg::ST_IDLE: begin
          if (frame_da_valid) begin
            da_ff       <= frame_da;
            scan_idx_ff <= '0;
            state_ff    <= rx_filter_pkg::ST_SCAN;
          end
        end
        rx_filter_pkg::ST_SCAN: begin
          if (scan_idx_ff == IDX_W'(ENTRIES - 1)) begin
            state_ff <= rx_filter_pkg::ST_DECIDE;
          end else begin
            scan_idx_ff <= scan_idx_ff + IDX_W'(1);
          end
        end
        rx_filter_pkg::ST_DECIDE: begin
          state_ff <= rx_filter_pkg::ST_IDLE;
        end
        default: begin
          state_ff <= rx_filter_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmp_vld_ff <= 1'b0;
      cmp_idx_ff <= '0;
      hit_ff     <= 1'b0;
    end else begin
      cmp_vld_ff <= (state_ff == rx_filter_pkg::ST_SCAN);
      cmp_idx_ff <= scan_idx_ff;
      if (state_ff == rx_filter_pkg::ST_IDLE) begin
        hit_ff <= 1'b0;
      end else if (cmp_hit) begin
        hit_ff <= 1'b1;
      end
    end
  end

  // Only enabled entries take part in the match
  assign cmp_hit   = cmp_vld_ff && cam_en_ff[cmp_idx_ff] && (cam.rd_data == da_ff);
  assign final_hit = hit_ff || cmp_hit;
  assign decide    = (state_ff == rx_filter_pkg::ST_DECIDE);
  assign is_bcast  = &da_ff;
  assign is_mcast  = da_ff[`MCAST_BIT];

  always_comb begin
    nxt_accept = (final_hit != cfg_reject)
                 || (is_bcast && cfg_bcast)
                 || (!is_mcast && cfg_phys)
                 || (is_mcast && !is_bcast && cfg_mcast);
    nxt_compress = !is_bcast
                   && ((cfg_cmatch && !cfg_cmiss && final_hit)
                       || (cfg_cmiss && !cfg_cmatch && !final_hit));
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      decision_valid <= 1'b0;
      frame_accept   <= 1'b0;
      frame_reject   <= 1'b0;
      last_hit_ff    <= 1'b0;
      last_bcast_ff  <= 1'b0;
    end else begin
      decision_valid <= decide;
      frame_accept   <= decide && nxt_accept;
      frame_reject   <= decide && !nxt_accept;
      if (decide) begin
        last_hit_ff   <= final_hit;
        last_bcast_ff <= is_bcast;
      end
    end
  end

  // Request holds from the decision until the next frame starts
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      compress_request_out <= 1'b0;
      compress_request_oe  <= 1'b0;
    end else begin
      compress_request_oe <= cfg_cmatch || cfg_cmiss;
      if (decide) begin
        compress_request_out <= nxt_compress;
      end else if (frame_da_valid && !busy) begin
        compress_request_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc_cnt_ff <= `COUNT_RST;
      rej_cnt_ff <= `COUNT_RST;
    end else if (decide) begin
      acc_cnt_ff <= acc_cnt_ff + {15'h0000, nxt_accept};
      rej_cnt_ff <= rej_cnt_ff + {15'h0000, !nxt_accept};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_MATCH_COMPRESS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (decide && final_hit && !is_bcast && cfg_cmatch && !cfg_cmiss) |=> compress_request_out)
    else $error("compress not raised on table hit");

  AST_MISS_COMPRESS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (decide && !final_hit && !is_bcast && cfg_cmiss && !cfg_cmatch)
      |=> compress_request_out && decision_valid)
    else $error("compress not raised on table miss");

  AST_PIN_RELEASED: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!cfg_cmatch && !cfg_cmiss) [*2] |-> !compress_request_oe && !$rose(compress_request_oe))
    else $error("compress pin driven with both modes off");

  AST_NO_BCAST_COMPRESS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (decision_valid && last_bcast_ff) |-> !compress_request_out)
    else $error("compress raised for broadcast");

  AST_REJECT_HIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (decide && final_hit && cfg_reject && !is_bcast && !is_mcast && !cfg_phys)
      |=> frame_reject && !frame_accept)
    else $error("table hit not rejected");

  AST_ACCEPT_HIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (decide && final_hit && !cfg_reject) |=> frame_accept ##1 !frame_accept)
    else $error("table hit not accepted");

  AST_OTHERS_KEPT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (decide && cfg_reject && final_hit && !is_mcast && cfg_phys) |=> frame_accept)
    else $error("reject mode inverted promiscuous acceptance");

  AST_BCAST_WINS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (decide && is_bcast && cfg_bcast && cfg_reject) |=> frame_accept && !frame_reject)
    else $error("broadcast rejected");

  AST_ONE_DECISION: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (frame_da_valid && !busy) |=> !decision_valid [*8] ##10 decision_valid ##1 !decision_valid)
    else $error("decision not once, 18 cycles after address");
endmodule
`default_nettype wire

//--- src/rx_filter_params.svh
`ifndef RX_FILTER_PARAMS_SVH
`define RX_FILTER_PARAMS_SVH

`define CTRL_OFS       8'h00
`define CAM_EN_OFS     8'h04
`define CAM_IDX_OFS    8'h08
`define CAM_LO_OFS     8'h0c
`define CAM_MID_OFS    8'h10
`define CAM_HI_OFS     8'h14
`define CAM_CMD_OFS    8'h18
`define STATUS_OFS     8'h1c
`define COUNT_OFS      8'h20

`define CTRL_CMATCH_BIT 0
`define CTRL_CMISS_BIT  1
`define CTRL_REJECT_BIT 2
`define CTRL_BCAST_BIT  3
`define CTRL_PHYS_BIT   4
`define CTRL_MCAST_BIT  5
`define CTRL_W          6

`define CAM_CMD_LOAD_BIT 0
`define STAT_OVERRUN_BIT 5

`define CTRL_RST       6'h00
`define CAM_EN_RST     16'h0000
`define CAM_IDX_RST    4'h0
`define COUNT_RST      16'h0000

`define MCAST_BIT      40

`endif

//--- src/rx_filter_pkg.sv
package rx_filter_pkg;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_SCAN   = 3'b010,
    ST_DECIDE = 3'b100
  } scan_state_e;

  typedef logic [47:0] mac_addr_t;

endpackage

//--- test/frame_source.sv
`timescale 1ns/1ns
`default_nettype none
module frame_source (
  input  wire logic        clk_sys,        // System clock
  output logic             frame_da_valid, // Address complete pulse
  output logic [47:0]      frame_da        // Destination address
);
  initial begin
    frame_da_valid = 1'b0;
    frame_da       = 48'h0;
  end
  // One-cycle pulse; released lines then show the inverse so a late sample cannot match
  task automatic send(input logic [47:0] da);
    @(posedge clk_sys);
    frame_da_valid <= 1'b1;
    frame_da       <= da;
    @(posedge clk_sys);
    frame_da_valid <= 1'b0;
    frame_da       <= ~da;
  endtask
endmodule
`default_nettype wire

//--- test/test_rx_cam_compress_reject_filter.sv
`timescale 1ns/1ns
`default_nettype none
`include "rx_filter_params.svh"
module test_rx_cam_compress_reject_filter;
  localparam logic [31:0] CM     = 32'h1 << `CTRL_CMATCH_BIT;
  localparam logic [31:0] CN     = 32'h1 << `CTRL_CMISS_BIT;
  localparam logic [31:0] RJ     = 32'h1 << `CTRL_REJECT_BIT;
  localparam logic [31:0] BC     = 32'h1 << `CTRL_BCAST_BIT;
  localparam logic [31:0] PH     = 32'h1 << `CTRL_PHYS_BIT;
  localparam logic [31:0] MC     = 32'h1 << `CTRL_MCAST_BIT;
  localparam logic [47:0] DA_HIT = 48'h605040302010;
  localparam logic [47:0] DA_OFF = 48'h0a0b0c0d0e0f;
  localparam logic [47:0] DA_GRP = 48'h01005e000001;
  localparam logic [47:0] DA_ALL = 48'hffffffffffff;
  logic        clk_sys;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        frame_da_valid;
  logic [47:0] frame_da;
  logic        compress_request_out;
  logic        compress_request_oe;
  logic        decision_valid;
  logic        frame_accept;
  logic        frame_reject;
  logic [31:0] rd;
  logic        err;
  int          num_errors = 0;
  int          cmp_count  = 0;
  int          cycles     = 0;
  int          acc_n      = 0;
  int          rej_n      = 0;

  rx_cam_compress_reject_filter dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .frame_da_valid(frame_da_valid),
    .frame_da(frame_da), .compress_request_out(compress_request_out),
    .compress_request_oe(compress_request_oe), .decision_valid(decision_valid),
    .frame_accept(frame_accept), .frame_reject(frame_reject));
  frame_source src (.clk_sys(clk_sys), .frame_da_valid(frame_da_valid), .frame_da(frame_da));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    chk("pready", 32'h1, {31'h0, pready});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic load(input logic [3:0] idx, input logic [47:0] a);
    apb(`CAM_IDX_OFS, 1'b1, {28'h0, idx});
    apb(`CAM_LO_OFS, 1'b1, {16'h0, a[15:0]});
    apb(`CAM_MID_OFS, 1'b1, {16'h0, a[31:16]});
    apb(`CAM_HI_OFS, 1'b1, {16'h0, a[47:32]});
    apb(`CAM_CMD_OFS, 1'b1, 32'h1 << `CAM_CMD_LOAD_BIT);
  endtask

  // Expectations come from the acceptance and compress policy, not from the outputs
  task automatic run_case(input logic [31:0] c, input logic [47:0] da, input logic hit);
    logic grp;
    logic bc;
    logic acc;
    logic cmp;
    logic oe;
    int   lat;
    grp = da[`MCAST_BIT];
    bc  = (da == DA_ALL);
    acc = (hit ^ c[`CTRL_REJECT_BIT]) | (bc & c[`CTRL_BCAST_BIT]) |
          (!grp & c[`CTRL_PHYS_BIT]) | (grp & !bc & c[`CTRL_MCAST_BIT]);
    cmp = !bc && (c[`CTRL_CMATCH_BIT] ? hit : !hit);
    oe  = c[`CTRL_CMATCH_BIT] | c[`CTRL_CMISS_BIT];
    lat = 0;
    apb(`CTRL_OFS, 1'b1, c);
    src.send(da);
    do begin
      @(posedge clk_sys);
      lat++;
    end while (decision_valid !== 1'b1 && lat < 40);
    chk("latency", 32'h0000_0012, lat);
    chk("accept", {31'h0, acc}, {31'h0, frame_accept});
    chk("reject", {31'h0, !acc}, {31'h0, frame_reject});
    chk("drive enable", {31'h0, oe}, {31'h0, compress_request_oe});
    if (oe) chk("compress", {31'h0, cmp}, {31'h0, compress_request_out});
    if (acc) acc_n++;
    else rej_n++;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk("enable at reset", 32'h0, {31'h0, compress_request_oe});
    apb(`CTRL_OFS, 1'b0, 32'h0);
    chk("ctrl reset", {26'h0, `CTRL_RST}, rd);
    apb(`CAM_EN_OFS, 1'b0, 32'h0);
    chk("enable reset", {16'h0, `CAM_EN_RST}, rd);
    apb(`CAM_IDX_OFS, 1'b0, 32'h0);
    chk("index reset", {28'h0, `CAM_IDX_RST}, rd);
    apb(8'h24, 1'b0, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
  endtask

  task automatic t_load;
    load(4'hf, DA_HIT);
    load(4'h3, DA_OFF);
    apb(`CAM_EN_OFS, 1'b1, 32'h0000_8000);
    apb(`CAM_EN_OFS, 1'b0, 32'h0);
    chk("enable readback", 32'h0000_8000, rd);
    apb(`CAM_CMD_OFS, 1'b0, 32'h0);
    chk("load cmd reads zero", 32'h0, rd);
  endtask

  task automatic t_match;
    run_case(CM, DA_HIT, 1'b1);
    run_case(CM, DA_OFF, 1'b0);
    run_case(CM | BC, DA_ALL, 1'b0);
  endtask

  task automatic t_miss;
    run_case(CN, DA_OFF, 1'b0);
    run_case(CN, DA_HIT, 1'b1);
    run_case(CN, DA_GRP, 1'b0);
    run_case(CN | BC, DA_ALL, 1'b0);
    run_case(CN, DA_ALL, 1'b0);
  endtask

  task automatic t_off;
    run_case(32'h0, DA_HIT, 1'b1);
    run_case(BC, DA_HIT, 1'b1);
  endtask

  task automatic t_reject;
    run_case(RJ, DA_HIT, 1'b1);
    run_case(RJ, DA_OFF, 1'b0);
    run_case(RJ | BC, DA_ALL, 1'b0);
    run_case(RJ | BC, DA_HIT, 1'b1);
    run_case(RJ | PH, DA_OFF, 1'b0);
    run_case(RJ | MC, DA_GRP, 1'b0);
  endtask

  // Broadcast held in the table: only the broadcast setting may rescue it
  task automatic t_bcast_entry;
    load(4'h0, DA_ALL);
    apb(`CAM_EN_OFS, 1'b1, 32'h0000_8001);
    run_case(RJ | BC, DA_ALL, 1'b1);
    run_case(RJ, DA_ALL, 1'b1);
    run_case(CM | BC, DA_ALL, 1'b1);
    run_case(RJ | PH, DA_HIT, 1'b1);
    apb(`CAM_EN_OFS, 1'b1, 32'h0000_8000);
  endtask

  task automatic t_overrun;
    int n;
    n = 0;
    apb(`CTRL_OFS, 1'b1, 32'h0);
    src.send(DA_HIT);
    src.send(DA_OFF);
    do begin
      @(posedge clk_sys);
      n++;
    end while (decision_valid !== 1'b1 && n < 40);
    chk("first frame kept", 32'h1, {31'h0, frame_accept});
    acc_n++;
    apb(`STATUS_OFS, 1'b0, 32'h0);
    chk("overrun set", 32'h1, {31'h0, rd[`STAT_OVERRUN_BIT]});
    apb(`STATUS_OFS, 1'b1, 32'h1 << `STAT_OVERRUN_BIT);
    apb(`STATUS_OFS, 1'b0, 32'h0);
    chk("overrun cleared", 32'h0, {31'h0, rd[`STAT_OVERRUN_BIT]});
  endtask

  task automatic t_count;
    apb(`COUNT_OFS, 1'b0, 32'h0);
    chk("frame counts", {rej_n[15:0], acc_n[15:0]}, rd);
  endtask

  initial begin
    rst_n   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset;
    t_load;
    t_match;
    t_miss;
    t_off;
    t_reject;
    t_bcast_entry;
    t_overrun;
    t_count;
    wrap_up;
  end
endmodule
`default_nettype wire
